// File: rtl/irc_carrier_gen.v
// Infrared carrier generator with APB register access and level interrupt.
// Assumes interval_irq is a level or pulse synchronous to pclk and that the
// count clock is an enable derived from pclk by the programmable divider.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "irc_regs.vh"

module irc_carrier_gen (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        interval_timer_enable,
    input  wire        interval_irq,
    output wire        carrier_output_pin,
    output wire        carrier_match_irq,
    output wire        irq
);

    // Word offset compare, used by every register decode
    function sel_ofs;
        input [11:0] a;
        input [11:0] o;
        begin
            sel_ofs = (a[11:2] == o[11:2]);
        end
    endfunction

    // Software state
    reg  [31:0] ctrl_ff;
    reg  [7:0]  low_cmp_ff;
    reg  [7:0]  high_wr_ff;       // Latched value software wrote
    reg         high_pend_ff;
    reg  [1:0]  high_age_ff;      // Count clocks since the latch
    reg  [7:0]  high_cmp_ff;      // Value in use by the comparator
    reg  [1:0]  irq_stat_ff;
    reg  [1:0]  irq_mask_ff;

    // Timer state
    reg  [7:0]  div_ff;
    reg  [7:0]  count_ff;
    reg         sel_high_ff;
    reg         carrier_ff;
    reg         gate_ff;
    reg         out_ff;
    reg         started_ff;
    reg         intv_sync_ff;
    reg         intv_prev_ff;
    reg  [1:0]  xfer_ff;          // Shift for the gate copy delay
    reg         match_ff;

    wire        wr_en   = psel & penable & pwrite;
    wire        run     = ctrl_ff[`IRC_CTRL_RUN];
    wire        remote  = ctrl_ff[`IRC_CTRL_REMOTE];
    wire        shadow  = ctrl_ff[`IRC_CTRL_SHADOW];
    wire [7:0]  div_val = ctrl_ff[`IRC_CTRL_DIV_MSB:`IRC_CTRL_DIV_LSB];
    wire        tick    = (div_ff == div_val);
    wire        active  = run | interval_timer_enable;
    wire [7:0]  cmp_now = sel_high_ff ? high_cmp_ff : low_cmp_ff;
    wire        hit     = run & tick & (count_ff == cmp_now);
    wire        intv_rise = intv_sync_ff & ~intv_prev_ff;
    wire        high_ok = high_pend_ff & (high_age_ff == `IRC_HIGH_LOAD_CLKS);

    // Zero-wait slave; unmapped addresses read zero with no error
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Count clock enable from pclk
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 8'h00;
        end else if (!active || tick) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // Control, compare and mask registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff     <= `IRC_CTRL_RST;
            low_cmp_ff  <= `IRC_CMP_RST;
            irq_mask_ff <= `IRC_MASK_RST;
        end else if (wr_en) begin
            if (sel_ofs(paddr, `IRC_CTRL_OFS))
                ctrl_ff <= pwdata & 32'h0000_FF07;
            if (sel_ofs(paddr, `IRC_LOWCMP_OFS))
                low_cmp_ff <= pwdata[7:0];  // Caller keeps it still while running
            if (sel_ofs(paddr, `IRC_IRQ_MASK_OFS))
                irq_mask_ff <= pwdata[1:0];
        end
    end

    // High-width latch with three count clocks of settling
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_wr_ff   <= `IRC_CMP_RST;
            high_pend_ff <= 1'b0;
            high_age_ff  <= 2'h0;
            high_cmp_ff  <= `IRC_CMP_RST;
        end else begin
            if (wr_en && sel_ofs(paddr, `IRC_HIGHCMP_OFS)) begin
                high_wr_ff   <= pwdata[7:0];
                high_pend_ff <= 1'b1;
                high_age_ff  <= 2'h0;
                if (!run)
                    high_cmp_ff <= pwdata[7:0];  // Idle load is immediate
                if (!run)
                    high_pend_ff <= 1'b0;
            end else begin
                if (high_pend_ff && tick && !high_ok)
                    high_age_ff <= high_age_ff + 2'h1;
                if (hit && sel_high_ff && high_ok) begin
                    high_cmp_ff  <= high_wr_ff;
                    high_pend_ff <= 1'b0;
                end
            end
        end
    end

    // Counter, compare select and carrier
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff    <= 8'h00;
            sel_high_ff <= 1'b0;
            carrier_ff  <= 1'b0;
            started_ff  <= 1'b0;
            match_ff    <= 1'b0;
        end else begin
            match_ff <= hit;
            if (!run) begin
                count_ff    <= 8'h00;
                sel_high_ff <= 1'b0;
                carrier_ff  <= 1'b0;
                started_ff  <= 1'b0;
            end else if (tick) begin
                started_ff <= 1'b1;
                if (hit) begin
                    count_ff    <= 8'h00;
                    carrier_ff  <= ~carrier_ff;
                    sel_high_ff <= ~sel_high_ff;
                end else begin
                    count_ff <= count_ff + 8'h01;
                end
            end
        end
    end

    // Interval sync and gate copy on the second count clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            intv_sync_ff <= 1'b0;
            intv_prev_ff <= 1'b0;
            xfer_ff      <= 2'h0;
            gate_ff      <= 1'b0;
        end else if (!active) begin
            xfer_ff <= 2'h0;
            gate_ff <= 1'b0;
        end else if (tick) begin
            intv_sync_ff <= interval_irq;
            intv_prev_ff <= intv_sync_ff;
            xfer_ff      <= {xfer_ff[0], intv_rise};
            if (xfer_ff[0])
                gate_ff <= shadow & remote;
        end
    end

    // Output gating that cuts a high phase only when run is cleared
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ff <= 1'b0;
        end else if (!run) begin
            out_ff <= 1'b0;
        end else if (gate_ff) begin
            if (!out_ff && hit && !carrier_ff)
                out_ff <= 1'b1;
            else if (out_ff && hit && carrier_ff)
                out_ff <= 1'b0;
        end else if (out_ff && hit && carrier_ff) begin
            out_ff <= 1'b0;
        end else if (!out_ff) begin
            out_ff <= 1'b0;
        end
    end

    // Sticky status, cleared by write one; set wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= 2'h0;
        end else begin
            irq_stat_ff <= (irq_stat_ff
                & ~((wr_en && sel_ofs(paddr, `IRC_IRQ_STAT_OFS))
                    ? pwdata[1:0] : 2'h0))
                | {tick & intv_rise, hit};
        end
    end

    assign carrier_output_pin = out_ff;
    assign carrier_match_irq  = match_ff;
    assign irq = |(irq_stat_ff & irq_mask_ff);

    // Read mux registered at the setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (sel_ofs(paddr, `IRC_CTRL_OFS))
                prdata <= ctrl_ff;
            if (sel_ofs(paddr, `IRC_LOWCMP_OFS))
                prdata <= {24'h000000, low_cmp_ff};
            if (sel_ofs(paddr, `IRC_HIGHCMP_OFS))
                prdata <= {24'h000000, high_wr_ff};
            if (sel_ofs(paddr, `IRC_STATUS_OFS))
                prdata <= {27'h0, high_pend_ff, sel_high_ff, out_ff,
                           carrier_ff, gate_ff};
            if (sel_ofs(paddr, `IRC_IRQ_STAT_OFS))
                prdata <= {30'h0, irq_stat_ff};
            if (sel_ofs(paddr, `IRC_IRQ_MASK_OFS))
                prdata <= {30'h0, irq_mask_ff};
            if (sel_ofs(paddr, `IRC_COUNT_OFS))
                prdata <= {23'h0, started_ff, count_ff};
        end
    end

endmodule // irc_carrier_gen
`default_nettype wire

// File: rtl/irc_regs.vh
// Constants for the infrared carrier generator: APB offsets, fields, resets.
// Assumes a 32-bit APB with word-aligned registers; pclk at 125 MHz.
// Notes on behaviour
// - Counter clears to 0 and stays there while run enable is 0.
// - Run enable starts counting; carrier low until first match.
// - Low match: irq, invert carrier, clear counter, select high.
// - High match: irq, invert carrier, clear counter, select low.
// - Alternating matches give a carrier; duty follows both values.
// - Interval interrupt synchronised to the count clock as a pulse.
// - Synchronised pulse copies gate shadow bit ANDed with remote enable into active bit.
// - Active gate 0 with carrier low drives the pin low.
// - Gate 1 passes the carrier only from a carrier rising edge.
// - Gate dropping in carrier high keeps output high to phase end.
// - High-width writes latched, applied at a match of old value; with run enable 0 they load at once.
// - Latched high-width value needs three count clocks to load.
// - After transfer the next high match uses the new value.
// - Remote enable or shadow 0 gives low; both 1 give carrier.
// - Gate copy lands on second count clock after pulse rises.
`ifndef IRC_REGS_VH
`define IRC_REGS_VH

// Register byte offsets
`define IRC_CTRL_OFS      12'h000
`define IRC_LOWCMP_OFS    12'h004
`define IRC_HIGHCMP_OFS   12'h008
`define IRC_STATUS_OFS    12'h00C
`define IRC_IRQ_STAT_OFS  12'h010
`define IRC_IRQ_MASK_OFS  12'h014
`define IRC_COUNT_OFS     12'h018

// Control fields
`define IRC_CTRL_RUN      0
`define IRC_CTRL_REMOTE   1
`define IRC_CTRL_SHADOW   2
`define IRC_CTRL_DIV_LSB  8
`define IRC_CTRL_DIV_MSB  15

// Status fields
`define IRC_ST_GATE       0
`define IRC_ST_CARRIER    1
`define IRC_ST_OUT        2
`define IRC_ST_SELHIGH    3
`define IRC_ST_PENDING    4

// Interrupt bits
`define IRC_IRQ_MATCH     0
`define IRC_IRQ_INTERVAL  1

// Reset values
`define IRC_CTRL_RST      32'h0000_0000
`define IRC_CMP_RST       8'h01
`define IRC_MASK_RST      2'h0

// Count clocks before a latched high-width value may load
`define IRC_HIGH_LOAD_CLKS 2'h3

`endif

// File: sim/irc_checker.sv
// Port checker for the carrier generator.
// Assumes one pclk domain and presetn active low.
`timescale 1ns/100ps
`default_nettype none
module irc_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        interval_timer_enable,
    input wire logic        interval_irq,
    input wire logic        carrier_output_pin,
    input wire logic        carrier_match_irq,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Write access phase, and a run-clear write to control
    wire logic wr = psel & penable & pwrite;
    wire logic stop = wr & (paddr == 12'h000) & !pwdata[0];
    a_ready_high: assert property (pready) else $error("pready low");
    a_no_slverr: assert property (!pslverr) else $error("slave error");
    a_match_single: assert property (
        carrier_match_irq |=> !carrier_match_irq) else $error("long pulse");
    a_rise_at_match: assert property (
        $rose(carrier_output_pin) |-> ##[0:2] carrier_match_irq)
        else $error("pin rose off match");
    a_fall_at_match: assert property (
        $fell(carrier_output_pin) && !$past(wr) && !$past(wr, 2)
        |-> ##[0:2] carrier_match_irq) else $error("pin fell off match");
    a_high_hold: assert property (
        $rose(carrier_output_pin) && !psel |=> carrier_output_pin)
        else $error("high phase cut");
    a_stop_pin_low: assert property (
        stop |-> ##[1:3] !carrier_output_pin) else $error("pin not low");
    a_stop_quiet: assert property (
        stop && !interval_timer_enable |-> ##2 !carrier_match_irq [*3])
        else $error("match while stopped");
    a_mask_quiet: assert property (
        wr && paddr == 12'h014 && pwdata[1:0] == 2'h0 |=> !irq)
        else $error("masked irq high");
    a_upper_zero: assert property (psel && penable && !pwrite
        |-> prdata[31:16] == 16'h0000) else $error("upper bits set");
endmodule // irc_checker
`default_nettype wire

// File: sim/irc_ival_model.sv
// Interval timer model: repeating interval interrupt while enabled.
// Assumes the same pclk as the carrier block.
`timescale 1ns/100ps
`default_nettype none
module irc_ival_model #(
    parameter int PER = 40
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    output var  logic irq_out
);
    int cnt_ff;
    // Held 4 clocks so a slow count tick still sees the rise
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 0;
            irq_out <= 1'b0;
        end else begin
            cnt_ff <= (!run || cnt_ff == PER - 1) ? 0 : cnt_ff + 1;
            irq_out <= run && cnt_ff >= PER - 4;
        end
    end
endmodule // irc_ival_model
`default_nettype wire

// File: sim/test_ir_carrier_generator.sv
// Self-checking bench for the carrier generator over APB.
// Assumes zero-wait APB and a count tick every pclk (divider 0).
`timescale 1ns/100ps
`default_nettype none
module test_ir_carrier_generator;
    logic        pclk, presetn, psel, penable, pwrite, ival_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, q;
    wire logic   [31:0] prdata;
    wire logic   pready, pslverr, ival, pin, mirq, irq;
    int          bad_count, num_checks, n, a, hw_exp, hw_cnt;
    localparam logic [11:0] RA [5] = '{12'h0, 12'h4, 12'h8, 12'h14, 12'h18};
    localparam logic [31:0] RV [5] = '{32'h0, 32'h1, 32'h1, 32'h0, 32'h0};
    irc_carrier_gen DUT (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr,
        .interval_timer_enable(ival_en), .interval_irq(ival),
        .carrier_output_pin(pin), .carrier_match_irq(mirq), .irq);
    irc_ival_model #(.PER(40)) PART (.pclk, .presetn, .run(ival_en),
        .irq_out(ival));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One APB transfer; held until pready is seen high
    task automatic bus(input logic [11:0] ad, input logic w,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= ad;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            k++;
            if (k > 50) begin
                bad_count++;
                summarize();
            end
            @(posedge pclk);
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Clocks until the next match pulse, bounded
    task automatic gap(output int c);
        c = 0;
        do begin
            @(negedge pclk);
            c++;
        end while (mirq !== 1'b1 && c < 600);
        if (c >= 600) begin
            bad_count++;
            summarize();
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Every high phase on the pin must keep its full width
    always @(negedge pclk) begin
        if (pin === 1'b1)
            hw_cnt++;
        else begin
            if (hw_cnt != 0 && hw_exp != 0)
                chk(hw_cnt, hw_exp);
            hw_cnt = 0;
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, ival_en} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        {bad_count, num_checks, hw_exp, hw_cnt} = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (RA[i]) begin
            bus(RA[i], 1'b0, 32'h0);
            chk(q, RV[i]);
        end
        bus(12'h01C, 1'b1, 32'hFFFFFFFF);
        bus(12'h01C, 1'b0, 32'h0);
        chk(q, 32'h0);
        // Low width 3, high width 5: phases of 4 and 6 ticks
        // Low width only written while stopped
        bus(12'h004, 1'b1, 32'h3);
        bus(12'h008, 1'b1, 32'h5);
        repeat (10) @(posedge pclk);
        bus(12'h018, 1'b0, 32'h0);
        chk(q[7:0], 8'h00);
        bus(12'h000, 1'b1, 32'h7);
        gap(n);
        bus(12'h00C, 1'b0, 32'h0);
        chk(q[4:0], 5'h0A);
        gap(n);
        gap(n);
        chk(n, 4);
        gap(n);
        chk(n, 6);
        // Sticky match status, then stop and clear
        bus(12'h014, 1'b1, 32'h1);
        bus(12'h000, 1'b1, 32'h6);
        bus(12'h018, 1'b0, 32'h0);
        chk(q[7:0], 8'h00);
        bus(12'h00C, 1'b0, 32'h0);
        chk(q[3:1], 3'h0);
        chk(irq, 1'b1);
        bus(12'h010, 1'b1, 32'h3);
        @(negedge pclk);
        chk(irq, 1'b0);
        // Gate opened by the interval event
        bus(12'h014, 1'b1, 32'h2);
        bus(12'h008, 1'b1, 32'h5);
        hw_exp = 6;
        bus(12'h000, 1'b1, 32'h7);
        ival_en <= 1'b1;
        n = 0;
        while (pin !== 1'b1 && n < 300) begin
            @(negedge pclk);
            n++;
        end
        chk(n < 300, 1'b1);
        // A gate that never opens ends the run here
        if (n >= 300)
            summarize();
        chk(irq, 1'b1);
        bus(12'h00C, 1'b0, 32'h0);
        chk(q[0], 1'b1);
        bus(12'h000, 1'b1, 32'h3);
        repeat (100) @(negedge pclk);
        chk(pin, 1'b0);
        // New high width while running takes over later
        hw_exp = 0;
        bus(12'h008, 1'b1, 32'h9);
        bus(12'h008, 1'b0, 32'h0);
        chk(q, 32'h9);
        repeat (4) gap(n);
        gap(a);
        gap(n);
        chk(a + n, 14);
        bus(12'h000, 1'b1, 32'h0);
        summarize();
    end
endmodule // test_ir_carrier_generator
bind irc_carrier_gen irc_checker CHK (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .interval_timer_enable, .interval_irq, .carrier_output_pin,
    .carrier_match_irq, .irq);
`default_nettype wire
